// ===== fbc_regs.svh
/*
  Offsets, field positions, reset values and timing counts of the flash,
  backlight and bias control bank.
  Assumes a 10 MHz core clock; included by the package and the top module.
*/
`ifndef FBC_REGS_SVH
`define FBC_REGS_SVH
`define FBC_I2C_ADDR 7'h11
`define FBC_BYTE_BITS 4'h8
`define FBC_A_FLASH 8'h07
`define FBC_A_BIAS_MODE 8'h08
`define FBC_A_GLOBAL 8'h09
`define FBC_A_OUT_EN 8'h0A
`define FBC_A_DRV_STAT 8'h0B
`define FBC_A_RAIL_CTL 8'h0C
`define FBC_A_SEQ_BOOST 8'h0D
`define FBC_A_POS_LVL 8'h0E
`define FBC_A_NEG_LVL 8'h0F
`define FBC_A_RAIL_STAT 8'h10
`define FBC_CFG_DFLT {8'h9C, 8'h5E, 8'h28, 8'h24, 8'h00, 8'h00, \
  8'h0A, 8'h0C, 8'h2F}
`define FBC_CFG_KEEP {8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, \
  8'h20, 8'hE0, 8'h00}
`define FBC_CFG_WMASK {8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h7F, \
  8'h7F, 8'hFF, 8'hFF}
`define FBC_RAIL_STAT_MASK 8'h7F
`define FBC_F_FREQ 7:6
`define FBC_F_ILIM 5
`define FBC_F_TMO 4:0
`define FBC_F_PM_EN 7
`define FBC_F_PM_RATE 6
`define FBC_F_EN_MODE 5
`define FBC_F_FOVP_SD 3
`define FBC_F_VMON_LVL 2:0
`define FBC_F_SRST 7
`define FBC_F_PWM_EN 6
`define FBC_F_PIN_SEL 5
`define FBC_F_STRB_SEL 4
`define FBC_F_TX_POL 3
`define FBC_F_TX_EN 2
`define FBC_F_VMON_MODE 1
`define FBC_F_VMON_EN 0
`define FBC_F_CH2_OFF 6
`define FBC_F_BOVP_SD 5
`define FBC_F_BL1 4
`define FBC_F_BL2 3
`define FBC_F_FL_MODE 2
`define FBC_F_FL_EN 1
`define FBC_F_BL_EN 0
`define FBC_F_PSAV 7
`define FBC_F_POS_EN 6
`define FBC_F_POS_GND 5
`define FBC_F_POS_DISC 4
`define FBC_F_NEG_EN 3
`define FBC_F_NEG_GND 2
`define FBC_F_NEG_DISC 1
`define FBC_F_STARTUP 0
`define FBC_F_DLY 7:6
`define FBC_F_SLEW 7:6
`define FBC_F_LVL 5:0
`define FBC_FLT_BOVP 7
`define FBC_FLT_FOVP 6
`define FBC_P_EN 0
`define FBC_P_POS 1
`define FBC_P_NEG 2
`define FBC_P_PWM 3
`define FBC_P_STRB 4
`define FBC_P_TX 5
`define FBC_CLK_NS 100
`define FBC_NS_PER_US 1000
`define FBC_TICK_US 100
`define FBC_TICK_CYC (`FBC_TICK_US * `FBC_NS_PER_US / `FBC_CLK_NS)
`define FBC_TICKS(us) ((us) / `FBC_TICK_US)
`define FBC_PM20_PER_US 50000
`define FBC_PM20_ON_US 2000
`define FBC_PM33_PER_US 30000
`define FBC_PM33_ON_US 1600
`define FBC_DLY1_US 1000
`define FBC_DLY2_US 2000
`define FBC_DLY5_US 5000
`define FBC_DISC_US 20000
`endif

// ===== fbc_pkg.sv
/*
  Types of the flash, backlight and bias control bank: serial engine
  states, the configuration array and the whole state record.
  Assumes fbc_regs.svh is on the include path.
*/
`include "fbc_regs.svh"
package fbc_pkg;
  typedef enum logic [3:0] {
    FBC_IDLE = 4'b0000,
    FBC_ADDR = 4'b0001,
    FBC_AACK = 4'b0010,
    FBC_REG = 4'b0011,
    FBC_REG_ACK = 4'b0100,
    FBC_WDAT = 4'b0101,
    FBC_WACK = 4'b0110,
    FBC_RDAT = 4'b0111,
    FBC_MACK = 4'b1000
  } fbc_i2c_e;
  typedef logic [`FBC_A_NEG_LVL:`FBC_A_FLASH][7:0] fbc_cfg_t;
  typedef logic [8:0] fbc_tick_t;
  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic scl_d;
    logic sda_d;
    fbc_i2c_e st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic rw;
    logic nack;
    logic sda_oe;
    fbc_cfg_t cfg;
    logic [7:0] drv_flags;
    logic [7:0] rail_flags;
    logic [5:0] pin_s0;
    logic [5:0] pin_s1;
    logic [7:0] drv_s0;
    logic [7:0] drv_s1;
    logic [7:0] rail_s0;
    logic [7:0] rail_s1;
    logic [9:0] tick_cnt;
    logic tick;
    fbc_tick_t pm_cnt;
    fbc_tick_t seq_cnt;
    fbc_tick_t pdis_cnt;
    fbc_tick_t ndis_cnt;
    logic pos_on;
    logic neg_on;
    logic pos_dis;
    logic neg_dis;
    logic pos_gnd;
    logic neg_gnd;
    logic bl_pwm;
    logic flash_trig;
    logic tx_mask;
    logic flash_sd;
    logic bl_sd;
  } fbc_state_s;
endpackage

// ===== fbc_top.sv
/*
  Control and status bank of a flash, backlight and display-bias power
  companion, reached through a serial two-wire target port.
  Assumes all pins are asynchronous to core_clk; all but resetn are synchronised here;
  SCL is slow enough (400 kHz) to be oversampled by the 10 MHz core clock.
*/
// Operation
// - Flash frequency field bits 7:6, 00 is 4MHz, 01 is 2MHz, resets 00.
// - Flash input current limit bit 5: clear 1.9A, set 2.8A, resets set.
// - Five-bit flash timeout is (code+1) times 32ms, resets to 512ms.
// - Periodic bit cycles enabled bias rails; rate bit picks 20Hz or 33Hz.
// - Bias turn-on needs main pin, or any of three pins in wide mode.
// - Flash overvoltage only reports at 0, shuts flash down at 1.
// - Backlight overvoltage only reports at 0, shuts backlight down at 1.
// - Input monitor threshold 2.5V to 3.2V, with enable and mode bits.
// - Bit 7 writes reset device, or all but bias; both read zero.
// - External PWM input drives backlight dimming only when enabled.
// - Pin-select bit hands rail enables from register bits to pins.
// - Strobe-source bit picks register command or strobe pin for flash.
// - Transmit-mask input honoured only when enabled, polarity selectable.
// - Flash enable, torch or flash mode, and second channel off bits.
// - Backlight master enable and two string enables, all reset off.
// - Read-only fault flags report driver faults and rail faults.
// - Power-saving bit bypasses input supply to the bias rails.
// - Ground-hold ties a disabled rail to ground, otherwise it floats.
// - Discharge bit discharges a rail for 20ms at shutdown.
// - Startup bit picks closed-loop or open-loop bias startup.
// - Sequencing field sets none, 1ms, 2ms or 5ms between the rails.
// - Six-bit level codes step 0.05V with their documented resets.
// - Two-bit slew fields pick rail transition rates, documented resets.
// - Registers sit behind a serial target at fixed address 0010001.
`timescale 1ns/100ps
`include "fbc_regs.svh"
module fbc_top import fbc_pkg::*; (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic en_pin,
  input wire logic positive_rail_pin,
  input wire logic negative_rail_pin,
  input wire logic pwm_pin,
  input wire logic strobe_pin,
  input wire logic tx_mask_pin,
  input wire logic [7:0] driver_fault_i,
  input wire logic [7:0] rail_fault_i,
  output logic [1:0] flash_freq_o,
  output logic flash_ilim_o,
  output logic [4:0] flash_timeout_o,
  output logic [2:0] vin_mon_level_o,
  output logic vin_mon_en_o,
  output logic vin_mon_standby_o,
  output logic flash_enable_o,
  output logic flash_mode_o,
  output logic flash_second_channel_off,
  output logic flash_trigger_o,
  output logic tx_mask_active_o,
  output logic flash_shutdown_o,
  output logic bl_enable_o,
  output logic bl_string1_en_o,
  output logic bl_string2_en_o,
  output logic bl_pwm_o,
  output logic bl_shutdown_o,
  output logic power_saving_o,
  output logic startup_open_loop_o,
  output logic [5:0] boost_rail_level_o,
  output logic [5:0] pos_level_o,
  output logic [5:0] neg_level_o,
  output logic [1:0] pos_slew_o,
  output logic [1:0] neg_slew_o,
  output logic pos_rail_on_o,
  output logic neg_rail_on_o,
  output logic pos_discharge_o,
  output logic neg_discharge_o,
  output logic pos_ground_o,
  output logic neg_ground_o
);
  localparam fbc_state_s RST_VAL = '{default: '0, st: FBC_IDLE,
                                     cfg: `FBC_CFG_DFLT};
  localparam fbc_cfg_t WMASK = `FBC_CFG_WMASK;
  localparam fbc_cfg_t KEEP = `FBC_CFG_KEEP;
  localparam fbc_cfg_t DFLT = `FBC_CFG_DFLT;

  fbc_state_s st_r;
  fbc_state_s st_nxt;

  // ==========================================================
  // Next state
  always_comb begin
    logic scl_rise, scl_fall, start, stop, load, wr;
    logic full_rst, part_rst, clr_drv, clr_rail, allow, pgate;
    logic pos_req, neg_req;
    logic [7:0] rd_byte, c08, c09, c0a, c0c;
    fbc_tick_t dly, pm_per, pm_on;
    scl_rise = st_r.scl_s[1] & ~st_r.scl_d;
    scl_fall = ~st_r.scl_s[1] & st_r.scl_d;
    start = st_r.scl_s[1] & st_r.scl_d & st_r.sda_d & ~st_r.sda_s[1];
    stop = st_r.scl_s[1] & st_r.scl_d & ~st_r.sda_d & st_r.sda_s[1];
    load = 1'h0;
    wr = 1'h0;
    full_rst = 1'h0;
    part_rst = 1'h0;
    clr_drv = 1'h0;
    clr_rail = 1'h0;
    rd_byte = 8'h00;
    allow = 1'h0;
    pgate = 1'h0;
    pos_req = 1'h0;
    neg_req = 1'h0;
    dly = '0;
    pm_per = '0;
    pm_on = '0;
    c08 = st_r.cfg[`FBC_A_BIAS_MODE];
    c09 = st_r.cfg[`FBC_A_GLOBAL];
    c0a = st_r.cfg[`FBC_A_OUT_EN];
    c0c = st_r.cfg[`FBC_A_RAIL_CTL];
    st_nxt = st_r;
    // Only the second stage of each synchroniser feeds logic
    st_nxt.scl_s = {st_r.scl_s[0], scl_i};
    st_nxt.sda_s = {st_r.sda_s[0], sda_i};
    st_nxt.scl_d = st_r.scl_s[1];
    st_nxt.sda_d = st_r.sda_s[1];
    st_nxt.pin_s0 = {tx_mask_pin, strobe_pin, pwm_pin, negative_rail_pin,
                     positive_rail_pin, en_pin};
    st_nxt.pin_s1 = st_r.pin_s0;
    st_nxt.drv_s0 = driver_fault_i;
    st_nxt.drv_s1 = st_r.drv_s0;
    st_nxt.rail_s0 = rail_fault_i;
    st_nxt.rail_s1 = st_r.rail_s0;
    if (st_r.tick_cnt == 10'(`FBC_TICK_CYC - 1)) begin
      st_nxt.tick_cnt = 10'h000;
      st_nxt.tick = 1'h1;
    end else begin
      st_nxt.tick_cnt = st_r.tick_cnt + 10'h001;
      st_nxt.tick = 1'h0;
    end
    // Any read outside the mapped window returns zero
    if (st_r.ptr == `FBC_A_DRV_STAT) begin
      rd_byte = st_r.drv_flags;
    end else if (st_r.ptr == `FBC_A_RAIL_STAT) begin
      rd_byte = st_r.rail_flags;
    end else if (st_r.ptr >= `FBC_A_FLASH && st_r.ptr <= `FBC_A_NEG_LVL) begin
      rd_byte = st_r.cfg[st_r.ptr[3:0]];
    end
    // ==========================================================
    // Serial target engine
    if (stop) begin
      st_nxt.st = FBC_IDLE;
      st_nxt.sda_oe = 1'h0;
    end else if (start) begin
      st_nxt.st = FBC_ADDR;
      st_nxt.cnt = 4'h0;
      st_nxt.sda_oe = 1'h0;
    end else begin
      case (st_r.st)
        FBC_ADDR, FBC_REG, FBC_WDAT: begin
          if (scl_rise) begin
            st_nxt.sh = {st_r.sh[6:0], st_r.sda_s[1]};
            st_nxt.cnt = st_r.cnt + 4'h1;
          end else if (scl_fall && st_r.cnt == `FBC_BYTE_BITS) begin
            st_nxt.sda_oe = 1'h1;
            if (st_r.st == FBC_ADDR) begin
              st_nxt.rw = st_r.sh[0];
              if (st_r.sh[7:1] == `FBC_I2C_ADDR) begin
                st_nxt.st = FBC_AACK;
              end else begin
                st_nxt.st = FBC_IDLE;
                st_nxt.sda_oe = 1'h0;
              end
            end else if (st_r.st == FBC_REG) begin
              st_nxt.ptr = st_r.sh;
              st_nxt.st = FBC_REG_ACK;
            end else begin
              wr = 1'h1;
              st_nxt.st = FBC_WACK;
            end
          end
        end
        FBC_AACK, FBC_REG_ACK, FBC_WACK: begin
          if (scl_fall) begin
            st_nxt.sda_oe = 1'h0;
            st_nxt.cnt = 4'h0;
            if (st_r.st == FBC_AACK && st_r.rw) begin
              load = 1'h1;
            end else if (st_r.st == FBC_AACK) begin
              st_nxt.st = FBC_REG;
            end else begin
              st_nxt.st = FBC_WDAT;
            end
          end
        end
        FBC_RDAT: begin
          if (scl_fall && st_r.cnt == (`FBC_BYTE_BITS - 4'h1)) begin
            st_nxt.st = FBC_MACK;
            st_nxt.sda_oe = 1'h0;
          end else if (scl_fall) begin
            st_nxt.cnt = st_r.cnt + 4'h1;
            st_nxt.sh = {st_r.sh[6:0], 1'h0};
            st_nxt.sda_oe = ~st_r.sh[6];
          end
        end
        FBC_MACK: begin
          if (scl_rise) begin
            st_nxt.nack = st_r.sda_s[1];
          end else if (scl_fall && st_r.nack) begin
            st_nxt.st = FBC_IDLE;
          end else if (scl_fall) begin
            st_nxt.cnt = 4'h0;
            load = 1'h1;
          end
        end
        default: begin
          st_nxt.st = FBC_IDLE;
          st_nxt.sda_oe = 1'h0;
        end
      endcase
    end
    // A read fetches the byte at the pointer; status clears on its read
    if (load) begin
      st_nxt.st = FBC_RDAT;
      st_nxt.sh = rd_byte;
      st_nxt.sda_oe = ~rd_byte[7];
      st_nxt.ptr = st_r.ptr + 8'h01;
      clr_drv = (st_r.ptr == `FBC_A_DRV_STAT);
      clr_rail = (st_r.ptr == `FBC_A_RAIL_STAT);
    end
    // ==========================================================
    // Register writes
    if (wr) begin
      st_nxt.ptr = st_r.ptr + 8'h01;
      if (st_r.ptr == `FBC_A_GLOBAL && st_r.sh[`FBC_F_SRST]) begin
        full_rst = 1'h1;
      end else if (st_r.ptr == `FBC_A_OUT_EN && st_r.sh[`FBC_F_SRST]) begin
        part_rst = 1'h1;
      end else if (st_r.ptr >= `FBC_A_FLASH &&
                   st_r.ptr <= `FBC_A_NEG_LVL) begin
        // Status slot and the self-clearing bits are masked off
        st_nxt.cfg[st_r.ptr[3:0]] = st_r.sh & WMASK[st_r.ptr[3:0]];
      end
    end
    // Set wins over the clear of a read in the same cycle
    st_nxt.drv_flags = (st_r.drv_flags & {8{~clr_drv}}) | st_r.drv_s1;
    st_nxt.rail_flags = (st_r.rail_flags & {8{~clr_rail}}) |
                        (st_r.rail_s1 & `FBC_RAIL_STAT_MASK);
    if (full_rst) begin
      st_nxt.cfg = DFLT;
      st_nxt.drv_flags = 8'h00;
      st_nxt.rail_flags = 8'h00;
    end else if (part_rst) begin
      st_nxt.cfg = (st_r.cfg & KEEP) | (DFLT & ~KEEP);
      st_nxt.drv_flags = 8'h00;
    end
    // ==========================================================
    // Driver gating
    st_nxt.bl_pwm = c09[`FBC_F_PWM_EN] & st_r.pin_s1[`FBC_P_PWM];
    st_nxt.flash_trig = c09[`FBC_F_STRB_SEL] ? st_r.pin_s1[`FBC_P_STRB] :
                        c0a[`FBC_F_FL_EN];
    st_nxt.tx_mask = c09[`FBC_F_TX_EN] &
      (st_r.pin_s1[`FBC_P_TX] == c09[`FBC_F_TX_POL]);
    st_nxt.flash_sd = c08[`FBC_F_FOVP_SD] & st_r.drv_s1[`FBC_FLT_FOVP];
    st_nxt.bl_sd = c0a[`FBC_F_BOVP_SD] & st_r.drv_s1[`FBC_FLT_BOVP];
    // ==========================================================
    // Bias rail sequencing
    allow = st_r.pin_s1[`FBC_P_EN];
    if (c08[`FBC_F_EN_MODE]) begin
      allow = st_r.pin_s1[`FBC_P_EN] | st_r.pin_s1[`FBC_P_POS] |
              st_r.pin_s1[`FBC_P_NEG];
    end
    if (c08[`FBC_F_PM_RATE]) begin
      pm_per = fbc_tick_t'(`FBC_TICKS(`FBC_PM33_PER_US));
      pm_on = fbc_tick_t'(`FBC_TICKS(`FBC_PM33_ON_US));
    end else begin
      pm_per = fbc_tick_t'(`FBC_TICKS(`FBC_PM20_PER_US));
      pm_on = fbc_tick_t'(`FBC_TICKS(`FBC_PM20_ON_US));
    end
    if (!c08[`FBC_F_PM_EN]) begin
      st_nxt.pm_cnt = '0;
    end else if (st_r.tick && st_r.pm_cnt >= pm_per - 9'h001) begin
      st_nxt.pm_cnt = '0;
    end else if (st_r.tick) begin
      st_nxt.pm_cnt = st_r.pm_cnt + 9'h001;
    end
    pgate = ~c08[`FBC_F_PM_EN] | (st_r.pm_cnt < pm_on);
    pos_req = allow & pgate & (c09[`FBC_F_PIN_SEL] ?
      st_r.pin_s1[`FBC_P_POS] : c0c[`FBC_F_POS_EN]);
    neg_req = allow & pgate & (c09[`FBC_F_PIN_SEL] ?
      st_r.pin_s1[`FBC_P_NEG] : c0c[`FBC_F_NEG_EN]);
    case (st_r.cfg[`FBC_A_SEQ_BOOST][`FBC_F_DLY])
      2'h1: dly = fbc_tick_t'(`FBC_TICKS(`FBC_DLY1_US));
      2'h2: dly = fbc_tick_t'(`FBC_TICKS(`FBC_DLY2_US));
      2'h3: dly = fbc_tick_t'(`FBC_TICKS(`FBC_DLY5_US));
      default: dly = '0;
    endcase
    // One counter times both orders: it runs while only the positive
    // rail is up, which is the gap in either direction
    if (!(st_r.pos_on && !st_r.neg_on)) begin
      st_nxt.seq_cnt = '0;
    end else if (st_r.tick && st_r.seq_cnt < dly) begin
      st_nxt.seq_cnt = st_r.seq_cnt + 9'h001;
    end
    st_nxt.neg_on = ~full_rst & neg_req & (st_r.neg_on | ~pos_req |
      (st_r.pos_on & (st_r.seq_cnt >= dly)));
    st_nxt.pos_on = ~full_rst & (pos_req | (st_r.pos_on & ~(neg_req |
      (~st_r.neg_on & (st_r.seq_cnt >= dly)))));
    if (st_r.pos_on && !st_nxt.pos_on && c0c[`FBC_F_POS_DISC]) begin
      st_nxt.pdis_cnt = fbc_tick_t'(`FBC_TICKS(`FBC_DISC_US));
    end else if (st_nxt.pos_on) begin
      st_nxt.pdis_cnt = '0;
    end else if (st_r.tick && st_r.pdis_cnt != '0) begin
      st_nxt.pdis_cnt = st_r.pdis_cnt - 9'h001;
    end
    if (st_r.neg_on && !st_nxt.neg_on && c0c[`FBC_F_NEG_DISC]) begin
      st_nxt.ndis_cnt = fbc_tick_t'(`FBC_TICKS(`FBC_DISC_US));
    end else if (st_nxt.neg_on) begin
      st_nxt.ndis_cnt = '0;
    end else if (st_r.tick && st_r.ndis_cnt != '0) begin
      st_nxt.ndis_cnt = st_r.ndis_cnt - 9'h001;
    end
    st_nxt.pos_dis = (st_nxt.pdis_cnt != '0);
    st_nxt.neg_dis = (st_nxt.ndis_cnt != '0);
    // Grounding waits for discharge so the two switches never overlap
    st_nxt.pos_gnd = ~st_nxt.pos_on & ~st_nxt.pos_dis &
                     c0c[`FBC_F_POS_GND];
    st_nxt.neg_gnd = ~st_nxt.neg_on & ~st_nxt.neg_dis &
                     c0c[`FBC_F_NEG_GND];
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= RST_VAL;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign sda_o = 1'h0; // Open drain: the pin is only ever pulled low
  assign sda_oe = st_r.sda_oe;
  assign flash_freq_o = st_r.cfg[`FBC_A_FLASH][`FBC_F_FREQ];
  assign flash_ilim_o = st_r.cfg[`FBC_A_FLASH][`FBC_F_ILIM];
  assign flash_timeout_o = st_r.cfg[`FBC_A_FLASH][`FBC_F_TMO];
  assign vin_mon_level_o = st_r.cfg[`FBC_A_BIAS_MODE][`FBC_F_VMON_LVL];
  assign vin_mon_en_o = st_r.cfg[`FBC_A_GLOBAL][`FBC_F_VMON_EN];
  assign vin_mon_standby_o = st_r.cfg[`FBC_A_GLOBAL][`FBC_F_VMON_MODE];
  assign flash_enable_o = st_r.cfg[`FBC_A_OUT_EN][`FBC_F_FL_EN];
  assign flash_mode_o = st_r.cfg[`FBC_A_OUT_EN][`FBC_F_FL_MODE];
  assign flash_second_channel_off =
    st_r.cfg[`FBC_A_OUT_EN][`FBC_F_CH2_OFF];
  assign flash_trigger_o = st_r.flash_trig;
  assign tx_mask_active_o = st_r.tx_mask;
  assign flash_shutdown_o = st_r.flash_sd;
  assign bl_enable_o = st_r.cfg[`FBC_A_OUT_EN][`FBC_F_BL_EN];
  assign bl_string1_en_o = st_r.cfg[`FBC_A_OUT_EN][`FBC_F_BL1];
  assign bl_string2_en_o = st_r.cfg[`FBC_A_OUT_EN][`FBC_F_BL2];
  assign bl_pwm_o = st_r.bl_pwm;
  assign bl_shutdown_o = st_r.bl_sd;
  assign power_saving_o = st_r.cfg[`FBC_A_RAIL_CTL][`FBC_F_PSAV];
  assign startup_open_loop_o =
    st_r.cfg[`FBC_A_RAIL_CTL][`FBC_F_STARTUP];
  assign boost_rail_level_o = st_r.cfg[`FBC_A_SEQ_BOOST][`FBC_F_LVL];
  assign pos_level_o = st_r.cfg[`FBC_A_POS_LVL][`FBC_F_LVL];
  assign neg_level_o = st_r.cfg[`FBC_A_NEG_LVL][`FBC_F_LVL];
  assign pos_slew_o = st_r.cfg[`FBC_A_POS_LVL][`FBC_F_SLEW];
  assign neg_slew_o = st_r.cfg[`FBC_A_NEG_LVL][`FBC_F_SLEW];
  assign pos_rail_on_o = st_r.pos_on;
  assign neg_rail_on_o = st_r.neg_on;
  assign pos_discharge_o = st_r.pos_dis;
  assign neg_discharge_o = st_r.neg_dis;
  assign pos_ground_o = st_r.pos_gnd;
  assign neg_ground_o = st_r.neg_gnd;

  // ==========================================================
  // Checks
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  pwm_gate_a: assert property (
    !st_r.cfg[`FBC_A_GLOBAL][`FBC_F_PWM_EN] |=> !bl_pwm_o)
    else $error("backlight pwm passed while disabled");
  strobe_src_a: assert property (
    st_r.cfg[`FBC_A_GLOBAL][`FBC_F_STRB_SEL] && st_r.pin_s1[`FBC_P_STRB]
    |=> flash_trigger_o)
    else $error("strobe pin did not trigger flash");
  tx_mask_a: assert property (
    st_r.cfg[`FBC_A_GLOBAL][`FBC_F_TX_EN] &&
    st_r.pin_s1[`FBC_P_TX] == st_r.cfg[`FBC_A_GLOBAL][`FBC_F_TX_POL]
    |=> tx_mask_active_o)
    else $error("transmit mask not honoured");
  flash_ovp_a: assert property (
    !st_r.cfg[`FBC_A_BIAS_MODE][`FBC_F_FOVP_SD] |=> !flash_shutdown_o)
    else $error("flash shut down in report-only mode");
  bl_ovp_a: assert property (
    st_r.cfg[`FBC_A_OUT_EN][`FBC_F_BOVP_SD] &&
    st_r.drv_s1[`FBC_FLT_BOVP] |=> bl_shutdown_o)
    else $error("backlight not shut down on overvoltage");
  bias_allow_a: assert property (
    !st_r.pin_s1[`FBC_P_EN] && !st_r.cfg[`FBC_A_BIAS_MODE][`FBC_F_EN_MODE]
    |=> !$rose(pos_rail_on_o) && !$rose(neg_rail_on_o))
    else $error("bias rail rose without main enable");
  ground_hold_a: assert property (
    pos_ground_o |-> !pos_rail_on_o && !pos_discharge_o)
    else $error("positive rail grounded while on");
  disc_start_a: assert property (
    $fell(pos_rail_on_o) && $past(st_r.cfg[`FBC_A_RAIL_CTL][`FBC_F_POS_DISC])
    |-> pos_discharge_o ##1 pos_discharge_o[*8])
    else $error("positive discharge did not start");
  srst_zero_a: assert property (
    !st_r.cfg[`FBC_A_GLOBAL][`FBC_F_SRST] &&
    !st_r.cfg[`FBC_A_OUT_EN][`FBC_F_SRST])
    else $error("reset bit reads back as one");
  sda_drive_a: assert property (
    sda_oe |-> st_r.st inside {FBC_AACK, FBC_REG_ACK, FBC_WACK, FBC_RDAT})
    else $error("data line driven outside ack or read");
  write_cov: cover property (st_r.st == FBC_WACK);
  read_cov: cover property (st_r.st == FBC_MACK ##1 st_r.st == FBC_RDAT);
  periodic_cov: cover property ($fell(pos_rail_on_o) && st_r.pm_cnt != '0);
  seq_cov: cover property ($rose(neg_rail_on_o) && st_r.seq_cnt != '0);
endmodule

// ===== fbc_i2c_host.sv
/*
  Two-wire controller model for the register port of fbc_top.
  Assumes the bench resolves SDA with a pull-up and feeds it back here.
*/
`timescale 1ns/100ps
`include "fbc_regs.svh"
module fbc_i2c_host (
  input wire logic core_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // ==========================================================
  // Bus cycles, SCL half period 400 ns, idle high between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic hp();
    repeat (4) @(posedge core_clk);
  endtask
  // SDA moves one edge after SCL falls, so no false start is seen
  task automatic bit_io(input logic b, output logic r);
    @(posedge core_clk);
    sda_low <= ~b;
    repeat (3) @(posedge core_clk);
    scl <= 1'b1;
    hp();
    r = sda;
    scl <= 1'b0;
  endtask
  task automatic start();
    @(posedge core_clk);
    sda_low <= 1'b0;
    hp();
    scl <= 1'b1;
    hp();
    sda_low <= 1'b1;
    hp();
    scl <= 1'b0;
  endtask
  task automatic stop();
    @(posedge core_clk);
    sda_low <= 1'b1;
    hp();
    scl <= 1'b1;
    hp();
    sda_low <= 1'b0;
    hp();
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic wr(input logic [6:0] dv, input logic [7:0] a,
      input logic [7:0] d, output logic ok);
    logic k0, k1, k2;
    start();
    wbyte({dv, 1'b0}, k0);
    wbyte(a, k1);
    wbyte(d, k2);
    stop();
    ok = k0 & k1 & k2;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic k;
    start();
    wbyte({`FBC_I2C_ADDR, 1'b0}, k);
    wbyte(a, k);
    start();
    wbyte({`FBC_I2C_ADDR, 1'b1}, k);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, k);
    stop();
  endtask
endmodule

// ===== tb_flash_bias_control_regs.sv
/*
  Self-checking bench of fbc_top: reset values, read-back, soft resets,
  PWM gating, fault flags, a wrong target address and rail enables.
  Assumes fbc_i2c_host as the controller and a pull-up on SDA.
*/
`timescale 1ns/100ps
`include "fbc_regs.svh"
module tb_flash_bias_control_regs;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic scl, sda_low, sda_oe, ok, fsd, bpwm, ch2, pos_on, pos_dis, pos_gnd;
  logic pwm_pin = 1'b0;
  logic [4:0] pins = 5'h00;
  logic [7:0] drv_flt = 8'h00, rail_flt = 8'h00, rv;
  logic [5:0] pos_lvl;
  wire [2:0] bl;
  int num_errors = 0, check_count = 0, cyc = 0;
  wire sda = ~(sda_low | sda_oe);
  fbc_top dut (.core_clk(core_clk), .resetn(resetn), .scl_i(scl),
    .sda_i(sda), .sda_o(), .sda_oe(sda_oe), .en_pin(pins[0]),
    .positive_rail_pin(pins[1]), .negative_rail_pin(pins[2]),
    .pwm_pin(pwm_pin), .strobe_pin(pins[3]), .tx_mask_pin(pins[4]),
    .driver_fault_i(drv_flt), .rail_fault_i(rail_flt), .flash_freq_o(),
    .flash_ilim_o(), .flash_timeout_o(), .vin_mon_level_o(),
    .vin_mon_en_o(), .vin_mon_standby_o(), .flash_enable_o(bl[1]),
    .flash_mode_o(), .flash_second_channel_off(ch2), .flash_trigger_o(),
    .tx_mask_active_o(), .flash_shutdown_o(fsd), .bl_enable_o(bl[0]),
    .bl_string1_en_o(bl[2]), .bl_string2_en_o(), .bl_pwm_o(bpwm),
    .bl_shutdown_o(), .power_saving_o(), .startup_open_loop_o(),
    .boost_rail_level_o(), .pos_level_o(pos_lvl), .neg_level_o(),
    .pos_slew_o(), .neg_slew_o(), .pos_rail_on_o(pos_on), .neg_rail_on_o(),
    .pos_discharge_o(pos_dis), .neg_discharge_o(), .pos_ground_o(pos_gnd),
    .neg_ground_o());
  fbc_i2c_host host (.core_clk(core_clk), .sda(sda), .scl(scl),
    .sda_low(sda_low));
  // ==========================================================
  // Checks and bus wrappers
  task automatic stop_test();
    if (num_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e,
      input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    host.wr(`FBC_I2C_ADDR, a, d, ok);
    chk("ack", 8'h01, {7'h00, ok});
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, rv);
    chk($sformatf("reg %h", a), e, rv);
  endtask
  task automatic t_reset();
    logic [7:0] dv [10] = '{8'h2F, 8'h0C, 8'h0A, 8'h00, 8'h00, 8'h24,
      8'h28, 8'h5E, 8'h9C, 8'h00};
    for (int i = 0; i < 10; i++) rchk(8'h07 + 8'(i), dv[i]);
  endtask
  task automatic t_rw();
    for (int i = 7; i < 16; i++)
      if (i != 11) w(8'(i), 8'h5A);
    for (int i = 7; i < 16; i++)
      if (i != 11) rchk(8'(i), 8'h5A);
    chk("ch2", 8'h01, {7'h00, ch2});
    chk("pos", 8'h1A, {2'b00, pos_lvl});
    w(8'h0B, 8'hFF);
    rchk(8'h0B, 8'h00);
    rchk(8'h20, 8'h00);
    w(8'h0A, 8'h13);
    chk("bl", 8'h07, {5'h00, bl});
  endtask
  task automatic t_srst();
    w(8'h0A, 8'h80);
    rchk(8'h0A, 8'h00);
    rchk(8'h07, 8'h2F);
    rchk(8'h0E, 8'h5A);
    w(8'h09, 8'h80);
    rchk(8'h09, 8'h0A);
    rchk(8'h0E, 8'h5E);
  endtask
  task automatic t_pwm();
    @(posedge core_clk) pwm_pin <= 1'b1;
    repeat (6) @(posedge core_clk);
    chk("pwm", 8'h00, {7'h00, bpwm});
    w(8'h09, 8'h4A);
    chk("pwm", 8'h01, {7'h00, bpwm});
  endtask
  task automatic t_fault();
    @(posedge core_clk) drv_flt <= 8'h40;
    repeat (6) @(posedge core_clk);
    chk("fsd", 8'h01, {7'h00, fsd});
    w(8'h08, 8'h04);
    chk("fsd", 8'h00, {7'h00, fsd});
    @(posedge core_clk) drv_flt <= 8'h00;
    rchk(8'h0B, 8'h40);
    rchk(8'h0B, 8'h00);
    host.wr(7'h12, 8'h08, 8'h00, ok);
    chk("nack", 8'h00, {7'h00, ok});
    rchk(8'h08, 8'h04);
  endtask
  // Main pin gates the register enable, then the pins take over
  task automatic t_rail();
    w(8'h0C, 8'h74);
    chk("pos on", 8'h00, {7'h00, pos_on});
    chk("pos gnd", 8'h01, {7'h00, pos_gnd});
    @(posedge core_clk) pins <= 5'h19;
    repeat (6) @(posedge core_clk);
    chk("pos on", 8'h01, {7'h00, pos_on});
    chk("pos gnd", 8'h00, {7'h00, pos_gnd});
    w(8'h09, 8'h7E);
    chk("pos on", 8'h00, {7'h00, pos_on});
    chk("pos dis", 8'h01, {7'h00, pos_dis});
    chk("pos gnd", 8'h00, {7'h00, pos_gnd});
  endtask
  // ==========================================================
  // Clock, reset, hang guard and sequence
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      num_errors++;
      stop_test();
    end
  end
  initial begin
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_reset();
    t_rw();
    t_srst();
    t_pwm();
    t_fault();
    t_rail();
    stop_test();
  end
endmodule
